/* File: mmlc_pkg.sv */
// shared constants, types and the reply text of the modem mode and led controller
`default_nettype none
package mmlc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ    = 50_000_000;
  localparam int GUARD_MS  = 1000;
  localparam int GUARD_CYC = CLK_HZ / 1000 * GUARD_MS;
  localparam int CYCLE_MS  = 300;
  localparam int CYCLE_CYC = CLK_HZ / 1000 * CYCLE_MS;
  localparam int SYNC_WAIT = 2;

  // ----------------------------------------------------------------
  // register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_REGNUM = 5'h08;
  localparam logic [4:0] OFF_SIGSTR = 5'h0C;
  localparam logic [4:0] OFF_TXDATA = 5'h10;
  localparam logic [4:0] CTRL_RST   = 5'h00;
  localparam int ST_MODE    = 0;
  localparam int ST_SYNC    = 1;
  localparam int ST_FORCE   = 2;
  localparam int ST_CMDSEEN = 3;
  localparam int ST_CLASS   = 4;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UNIT_PRIMARY   = 2'h0,
    UNIT_SECONDARY = 2'h1,
    UNIT_STANDBY   = 2'h2,
    UNIT_REMOTE    = 2'h3
  } mmlc_unit_e;
  localparam logic [1:0] HS_ALT1 = 2'h1;
  localparam logic [7:0] SIG_TH1 = 8'h40;
  localparam logic [7:0] SIG_TH2 = 8'h80;
  localparam logic [7:0] SIG_TH3 = 8'hC0;

  typedef struct packed {
    logic [1:0] handshake_alternate_option;
    logic       serial_channel_mode_setting;
    mmlc_unit_e unit;
  } mmlc_ctrl_s;

  typedef struct packed {
    logic       rs485;
    logic       tx;
    logic       rx;
    logic [2:0] signal_strength_bar;
  } mmlc_led_s;

  typedef enum logic {MODE_DATA = 1'b0, MODE_CMD = 1'b1} mmlc_mode_e;
  typedef enum logic [1:0] {
    ESC_IDLE = 2'b00,
    ESC_PLUS = 2'b01,
    ESC_POST = 2'b11
  } mmlc_esc_e;
  typedef enum logic [2:0] {
    CMD_NONE   = 3'h0,
    CMD_ANSWER = 3'h1,
    CMD_STORE  = 3'h2,
    CMD_VIEW   = 3'h3,
    CMD_QUERY  = 3'h4,
    CMD_HELP   = 3'h5,
    CMD_OTHER  = 3'h6
  } mmlc_cmd_e;

  // ----------------------------------------------------------------
  // characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_T     = 8'h54;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_AMP   = 8'h26;
  localparam logic [7:0] CH_W     = 8'h57;
  localparam logic [7:0] CH_V     = 8'h56;
  localparam logic [7:0] CH_EQ    = 8'h3D;
  localparam logic [7:0] CH_Q     = 8'h3F;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_9     = 8'h39;

  localparam logic [4:0] REPLY_LEN = 5'h12;
  localparam logic [8*18-1:0] REPLY_TEXT =
    {8'h0D, 8'h0A, 8'h4E, 8'h4F, 8'h20, 8'h43, 8'h41, 8'h52, 8'h52,
     8'h49, 8'h45, 8'h52, 8'h0D, 8'h0A, 8'h4F, 8'h4B, 8'h0D, 8'h0A};

  function automatic logic [7:0] reply_char(input logic [4:0] idx);
    reply_char = REPLY_TEXT[8*(17-int'(idx)) +: 8];
  endfunction

endpackage
`default_nettype wire

/* File: mmlc_top.sv */
// modem mode controller: escape and command decode, led driver, register slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module mmlc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and control
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         clk_en,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (clk_en && push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_r <= (wr_r == AW'(D-1)) ? '0 : AW'(wr_r + 1'b1);
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(D-1)) ? '0 : AW'(rd_r + 1'b1);
      end
      cnt_r <= (AW+1)'(cnt_r + push - pop);
    end
  end
endmodule

module mmlc_top import mmlc_pkg::*; #(
  parameter int unsigned GUARD_CYCLES = GUARD_CYC,
  parameter int unsigned CYCLE_CYCLES = CYCLE_CYC,
  parameter int          FIFO_DEPTH   = 8
) (
  // clock and control
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // host serial bytes
  input  wire logic        ser_rx_valid,
  input  wire logic [7:0]  ser_rx_data,
  output logic             ser_rx_ready,
  output logic             ser_tx_valid,
  output logic [7:0]       ser_tx_data,
  input  wire logic        ser_tx_ready,
  // radio bytes and link state
  output logic             rf_tx_valid,
  output logic [7:0]       rf_tx_data,
  input  wire logic        rf_tx_ready,
  input  wire logic        rf_rx_valid,
  input  wire logic [7:0]  rf_rx_data,
  output logic             rf_rx_ready,
  input  wire logic        rf_transmitting,
  input  wire logic        rf_synced,
  input  wire logic        rf_rx_busy,
  input  wire logic        rf_pkt_ok,
  input  wire logic [7:0]  rf_pkt_level,
  // pins and status
  input  wire logic        cfg_button_n,
  output var mmlc_led_s    leds,
  output logic             serial_default,
  output logic             nv_store
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mmlc_mode_e  mode_r;
  mmlc_esc_e   esc_r;
  mmlc_ctrl_s  ctrl_r;
  mmlc_cmd_e   cls_r;
  mmlc_cmd_e   cls_nxt;
  logic        btn_s1_r, btn_s2_r, force_r, boot_done_r;
  logic [1:0]  boot_cnt_r, plus_cnt_r, flush_cnt_r;
  logic [31:0] sil_r, cyc_cnt_r;
  logic        sil_full, esc_break, esc_done, rx_take;
  logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [7:0]  f_in_data, f_out_data, ch;
  logic        cmd_take, cmd_evt, cmd_seen_r;
  logic [3:0]  pos_r;
  logic        at_ok_r;
  logic [7:0]  c2_r, c3_r, prev_r, last_r;
  logic [9:0]  num_r, regnum_r;
  logic        rply_act_r;
  logic [4:0]  rply_idx_r;
  logic        tx_v_r, tx_load, sw_tx_req, sw_take;
  logic [7:0]  tx_d_r;
  logic        ack_r, req, sel_tx, wr_fire;
  logic [7:0]  lvl_r [4];
  logic [9:0]  lvl_sum;
  logic [7:0]  sig_r;
  logic        got_valid_r, link_ok;
  logic [2:0]  cyc_sel_r, bar_lvl;
  mmlc_led_s   led_nxt;

  // ----------------------------------------------------------------
  // config button and boot
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      btn_s1_r <= 1'b1;
      btn_s2_r <= 1'b1;
    end else if (clk_en) begin
      btn_s1_r <= cfg_button_n;
      btn_s2_r <= btn_s1_r;
    end
  end

  // button level is caught only once the synchroniser holds real samples
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_cnt_r  <= '0;
      boot_done_r <= 1'b0;
    end else if (clk_en && !boot_done_r) begin
      boot_cnt_r  <= 2'(boot_cnt_r + 1'b1);
      boot_done_r <= (boot_cnt_r == 2'(SYNC_WAIT));
    end
  end

  // ----------------------------------------------------------------
  // mode
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r  <= MODE_DATA;
      force_r <= 1'b0;
    end else if (clk_en) begin
      if (!boot_done_r && boot_cnt_r == 2'(SYNC_WAIT) && !btn_s2_r) begin
        mode_r  <= MODE_CMD;
        force_r <= 1'b1;
      end else if (esc_done) begin
        mode_r <= MODE_CMD;
      end else if (cmd_evt && cls_nxt == CMD_ANSWER) begin
        mode_r  <= MODE_DATA;
        force_r <= 1'b0;
      end
    end
  end
  assign serial_default = force_r;

  // ----------------------------------------------------------------
  // escape detector in front of the fifo
  // ----------------------------------------------------------------
  assign rx_take   = ser_rx_valid && ser_rx_ready;
  assign sil_full  = (sil_r >= GUARD_CYCLES);
  assign esc_break = (mode_r == MODE_DATA) && (esc_r != ESC_IDLE)
                     && ser_rx_valid
                     && (ser_rx_data != CH_PLUS || esc_r == ESC_POST);
  assign esc_done  = (mode_r == MODE_DATA) && (esc_r == ESC_POST)
                     && sil_full;
  // the breaking byte waits until the held pluses are flushed ahead of it
  assign ser_rx_ready = f_in_ready && (flush_cnt_r == '0) && !esc_break;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sil_r <= '0;
    end else if (clk_en) begin
      if (rx_take) begin
        sil_r <= '0;
      end else if (!sil_full) begin
        sil_r <= sil_r + 32'd1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      esc_r       <= ESC_IDLE;
      plus_cnt_r  <= '0;
      flush_cnt_r <= '0;
    end else if (clk_en) begin
      if (flush_cnt_r != '0 && f_in_ready) begin
        flush_cnt_r <= 2'(flush_cnt_r - 1'b1);
      end
      if (mode_r != MODE_DATA || esc_done) begin
        esc_r      <= ESC_IDLE;
        plus_cnt_r <= '0;
      end else if (esc_break) begin
        esc_r       <= ESC_IDLE;
        flush_cnt_r <= plus_cnt_r;
        plus_cnt_r  <= '0;
      end else if (rx_take && ser_rx_data == CH_PLUS) begin
        unique case (esc_r)
          ESC_IDLE: begin
            if (sil_full) begin
              esc_r      <= ESC_PLUS;
              plus_cnt_r <= 2'h1;
            end
          end
          ESC_PLUS: begin
            plus_cnt_r <= 2'(plus_cnt_r + 1'b1);
            if (plus_cnt_r == 2'h2) begin
              esc_r <= ESC_POST;
            end
          end
          ESC_POST: esc_r <= ESC_POST;
        endcase
      end
    end
  end

  always_comb begin
    f_in_valid = 1'b0;
    f_in_data  = ser_rx_data;
    if (flush_cnt_r != '0) begin
      f_in_valid = 1'b1;
      f_in_data  = CH_PLUS;
    end else if (rx_take) begin
      f_in_valid = (mode_r == MODE_CMD) || (ser_rx_data != CH_PLUS)
                   || (esc_r == ESC_IDLE && !sil_full);
    end
  end

  mmlc_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .in_valid  (f_in_valid),
    .in_data   (f_in_data),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (f_out_ready)
  );

  // fifo drains to the air in data mode and to the decoder otherwise
  assign rf_tx_valid = f_out_valid && (mode_r == MODE_DATA);
  assign rf_tx_data  = f_out_data;
  assign f_out_ready = (mode_r == MODE_DATA) ? rf_tx_ready : 1'b1;
  assign cmd_take    = f_out_valid && (mode_r == MODE_CMD);
  assign ch          = f_out_data;

  // ----------------------------------------------------------------
  // command line decoder
  // ----------------------------------------------------------------
  assign cmd_evt = cmd_take && (ch == CH_CR) && (pos_r != '0);

  always_comb begin
    cls_nxt = CMD_OTHER;
    if (at_ok_r && pos_r == 4'h3 && c2_r == CH_A) begin
      cls_nxt = CMD_ANSWER;
    end else if (at_ok_r && pos_r == 4'h4 && c2_r == CH_AMP) begin
      if (c3_r == CH_W) begin
        cls_nxt = CMD_STORE;
      end else if (c3_r == CH_V) begin
        cls_nxt = CMD_VIEW;
      end
    end else if (at_ok_r && pos_r >= 4'h5 && c2_r == CH_S
                 && last_r == CH_Q) begin
      if (prev_r == CH_EQ) begin
        cls_nxt = CMD_QUERY;
      end else if (prev_r == CH_SLASH) begin
        cls_nxt = CMD_HELP;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_r   <= '0;
      at_ok_r <= 1'b0;
      c2_r    <= '0;
      c3_r    <= '0;
      prev_r  <= '0;
      last_r  <= '0;
      num_r   <= '0;
    end else if (clk_en && cmd_take) begin
      if (ch == CH_CR) begin
        pos_r <= '0;
        num_r <= '0;
      end else begin
        if (pos_r != 4'hF) begin
          pos_r <= 4'(pos_r + 1'b1);
        end
        if (pos_r == 4'h0) at_ok_r <= (ch == CH_A);
        if (pos_r == 4'h1) at_ok_r <= at_ok_r && (ch == CH_T);
        if (pos_r == 4'h2) c2_r <= ch;
        if (pos_r == 4'h3) c3_r <= ch;
        prev_r <= last_r;
        last_r <= ch;
        if (pos_r >= 4'h3 && ch >= CH_0 && ch <= CH_9) begin
          num_r <= 10'(num_r * 10'h00A + {6'h00, ch[3:0]});
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cls_r      <= CMD_NONE;
      regnum_r   <= '0;
      cmd_seen_r <= 1'b0;
      nv_store   <= 1'b0;
    end else if (clk_en) begin
      nv_store <= cmd_evt && cls_nxt == CMD_STORE;
      if (cmd_evt) begin
        cls_r      <= cls_nxt;
        regnum_r   <= num_r;
        cmd_seen_r <= 1'b1;
      end else if (wr_fire && avs_address == OFF_STATUS
                   && avs_writedata[ST_CMDSEEN]) begin
        cmd_seen_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial transmit: reply text, software bytes or radio data
  // ----------------------------------------------------------------
  assign tx_load      = !tx_v_r || ser_tx_ready;
  assign sw_take      = sw_tx_req && ((mode_r == MODE_DATA)
                        || (!rply_act_r && tx_load));
  assign rf_rx_ready  = (mode_r == MODE_DATA) ? tx_load : 1'b1;
  assign ser_tx_valid = tx_v_r;
  assign ser_tx_data  = tx_d_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rply_act_r <= 1'b0;
      rply_idx_r <= '0;
    end else if (clk_en) begin
      if (esc_done || (!boot_done_r && boot_cnt_r == 2'(SYNC_WAIT)
                       && !btn_s2_r)) begin
        rply_act_r <= 1'b1;
        rply_idx_r <= '0;
      end else if (rply_act_r && tx_load) begin
        rply_idx_r <= 5'(rply_idx_r + 1'b1);
        rply_act_r <= (rply_idx_r != 5'(REPLY_LEN - 1'b1));
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_v_r <= 1'b0;
      tx_d_r <= '0;
    end else if (clk_en && tx_load) begin
      tx_v_r <= 1'b0;
      if (mode_r == MODE_CMD && rply_act_r) begin
        tx_v_r <= 1'b1;
        tx_d_r <= reply_char(rply_idx_r);
      end else if (mode_r == MODE_CMD && sw_tx_req) begin
        tx_v_r <= 1'b1;
        tx_d_r <= avs_writedata[7:0];
      end else if (mode_r == MODE_DATA && rf_rx_valid) begin
        tx_v_r <= 1'b1;
        tx_d_r <= rf_rx_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  assign req             = avs_read || avs_write;
  assign sel_tx          = avs_write && (avs_address == OFF_TXDATA);
  assign sw_tx_req       = sel_tx && !ack_r;
  assign avs_waitrequest = req && !ack_r;
  assign wr_fire         = avs_write && ack_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
    end else if (clk_en) begin
      ack_r <= !ack_r && req && (!sel_tx || sw_take);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (clk_en && wr_fire && avs_address == OFF_CTRL) begin
      ctrl_r <= avs_writedata[4:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= '0;
    end else if (clk_en && avs_read && !ack_r) begin
      unique case (avs_address)
        OFF_CTRL:   avs_readdata <= {27'h0000000, ctrl_r};
        OFF_STATUS: avs_readdata <= {25'h0000000, cls_r, cmd_seen_r,
                                     force_r, rf_synced, mode_r};
        OFF_REGNUM: avs_readdata <= {22'h000000, regnum_r};
        OFF_SIGSTR: avs_readdata <= {24'h000000, sig_r};
        default:    avs_readdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // signal strength
  // ----------------------------------------------------------------
  assign lvl_sum = 10'(lvl_r[0]) + 10'(lvl_r[1]) + 10'(lvl_r[2])
                 + 10'(lvl_r[3]);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_r <= '{default: '0};
      sig_r <= '0;
    end else if (clk_en) begin
      if (rf_pkt_ok) begin
        lvl_r[0] <= rf_pkt_level;
        for (int i = 1; i < 4; i++) begin
          lvl_r[i] <= lvl_r[i-1];
        end
      end
      sig_r <= lvl_sum[9:2];
    end
  end

  assign bar_lvl = {sig_r >= SIG_TH3, sig_r >= SIG_TH2,
                    sig_r >= SIG_TH1};
  // a primary coordinator makes the sync, so it never waits for it
  assign link_ok = (ctrl_r.unit == UNIT_PRIMARY) || rf_synced;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      got_valid_r <= 1'b0;
    end else if (clk_en) begin
      if (rf_pkt_ok && link_ok) begin
        got_valid_r <= 1'b1;
      end else if (!link_ok) begin
        got_valid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // leds
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_cnt_r <= '0;
      cyc_sel_r <= 3'h1;
    end else if (clk_en) begin
      if (link_ok || mode_r == MODE_CMD) begin
        cyc_cnt_r <= '0;
        cyc_sel_r <= 3'h1;
      end else if (cyc_cnt_r >= CYCLE_CYCLES - 1) begin
        cyc_cnt_r <= '0;
        cyc_sel_r <= {cyc_sel_r[1:0], cyc_sel_r[2]};
      end else begin
        cyc_cnt_r <= cyc_cnt_r + 32'd1;
      end
    end
  end

  always_comb begin
    led_nxt       = '0;
    led_nxt.rs485 = ctrl_r.serial_channel_mode_setting && !force_r
                    && ctrl_r.handshake_alternate_option == HS_ALT1;
    if (mode_r == MODE_CMD) begin
      led_nxt = '0;
    end else if (ctrl_r.unit == UNIT_PRIMARY) begin
      led_nxt.rx = rf_rx_busy && got_valid_r;
      led_nxt.tx = rf_transmitting;
      led_nxt.signal_strength_bar = bar_lvl;
    end else if (!rf_synced) begin
      led_nxt.signal_strength_bar = cyc_sel_r;
    end else begin
      led_nxt.rx = got_valid_r;
      led_nxt.tx = rf_transmitting;
      led_nxt.signal_strength_bar = bar_lvl;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      leds <= '0;
    end else if (clk_en) begin
      leds <= led_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: mmlc_top_checker.sv */
// port checker of the modem mode and led controller
`timescale 1ns/1ps
`default_nettype none
module mmlc_top_checker import mmlc_pkg::*; (
  // watched ports
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       cfg_button_n,
  input wire logic       rf_transmitting,
  input wire logic       rf_tx_valid,
  input wire logic       rf_tx_ready,
  input wire logic [7:0] rf_tx_data,
  input wire mmlc_led_s  leds,
  input wire logic       serial_default,
  input wire logic       nv_store
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_cmd_dark: assert property (
    serial_default |=> leds[4:0] == 5'h00) else $error("leds lit in command");
  chk_rs485_gate: assert property (
    serial_default |=> !leds.rs485) else $error("rs485 led under default");
  chk_tx_cause: assert property (
    leds.tx |-> $past(rf_transmitting)) else $error("tx led without send");
  chk_bar_shape: assert property (
    !(leds.signal_strength_bar inside {3'h5, 3'h6})) else $error("bar gap");
  chk_store_pulse: assert property (
    nv_store |=> !nv_store) else $error("store pulse too long");
  chk_boot_button: assert property (
    $rose(serial_default) |-> !$past(cfg_button_n, 3))
    else $error("default w/o button");
  chk_air_hold: assert property (
    rf_tx_valid && !rf_tx_ready |=> rf_tx_valid && $stable(rf_tx_data))
    else $error("air byte dropped under stall");
  chk_cmd_offline: assert property (
    serial_default |-> !rf_tx_valid) else $error("air data in command");
endmodule
bind mmlc_top mmlc_top_checker u_mmlc_top_checker (.*);
`default_nettype wire

/* File: mmlc_host.sv */
// host terminal model on the serial byte lanes
`timescale 1ns/1ps
`default_nettype none
module mmlc_host (
  // serial bytes
  input  wire logic       core_clk,
  output logic            ser_rx_valid,
  output logic [7:0]      ser_rx_data,
  input  wire logic       ser_rx_ready,
  input  wire logic       ser_tx_valid,
  input  wire logic [7:0] ser_tx_data,
  output logic            ser_tx_ready
);
  logic [7:0] got[$];
  initial {ser_rx_valid, ser_rx_data, ser_tx_ready} = 10'h000;
  // takes every other slot, so replies must hold under stall
  always @(posedge core_clk) begin
    if (ser_tx_valid && ser_tx_ready) got.push_back(ser_tx_data);
    ser_tx_ready <= ~ser_tx_ready;
  end
  task automatic send(input logic [7:0] b);
    {ser_rx_valid, ser_rx_data} <= {1'b1, b};
    do @(posedge core_clk); while (!ser_rx_ready);
    {ser_rx_valid, ser_rx_data} <= {1'b0, ~b}; // released lane goes stale
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* File: mmlc_top_tb.sv */
// self-checking bench of the modem mode and led controller
`timescale 1ns/1ps
`default_nettype none
module mmlc_top_tb import mmlc_pkg::*;;
  localparam int G = 40;
  logic        core_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
  logic        ser_rx_valid, ser_rx_ready, ser_tx_valid, ser_tx_ready;
  logic [7:0]  ser_rx_data, ser_tx_data, rf_tx_data, rf_rx_data = 8'h00;
  logic [7:0]  rf_pkt_level = 8'h00, air[$];
  logic        rf_tx_valid, rf_tx_ready = 1'b0, rf_rx_valid = 1'b0;
  logic        rf_rx_ready, rf_transmitting = 1'b0, rf_synced = 1'b0;
  logic        rf_rx_busy = 1'b0, rf_pkt_ok = 1'b0, cfg_button_n = 1'b0;
  logic        serial_default, nv_store;
  mmlc_led_s   leds;
  int          bad_count = 0, n_compared = 0, cyc = 0, stores = 0;
  mmlc_top #(.GUARD_CYCLES(G), .CYCLE_CYCLES(10)) u_mmlc_top (.*);
  mmlc_host u_mmlc_host (.*);
  always #10 core_clk = ~core_clk;
  // radio side stalls every other cycle
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    rf_tx_ready <= ~rf_tx_ready;
    stores <= stores + int'(nv_store);
    if (rf_tx_valid && rf_tx_ready) air.push_back(rf_tx_data);
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic idle(input int n); repeat (n) @(posedge core_clk); endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    {avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
    @(posedge core_clk);
  endtask
  task automatic line(input string s);
    foreach (s[i]) u_mmlc_host.send(s[i]);
  endtask
  task automatic reply_chk;
    string t = "\r\nNO CARRIER\r\nOK\r\n";
    foreach (t[i]) chk("reply", t[i], u_mmlc_host.got.pop_front());
  endtask
  task automatic t_boot;
    idle(120);
    chk("serial_default", 1'b1, serial_default);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("mode", 1'b1, rdv[0]);
    reply_chk();
    chk("leds", 6'h00, leds);
    line("ATA\r");
    idle(4);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("mode", 1'b0, rdv[0]);
  endtask
  task automatic t_leds;
    bus(1'b1, OFF_CTRL, 32'h0C);
    {rf_transmitting, rf_rx_busy, rf_synced} <= 3'h7;
    {rf_pkt_ok, rf_pkt_level} <= {1'b1, 8'h90};
    idle(4);
    rf_pkt_ok <= 1'b0;
    idle(3);
    chk("leds", 6'h3B, leds);
    bus(1'b0, OFF_SIGSTR, 32'h0);
    chk("level", 32'h90, rdv);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, rdv);
  endtask
  task automatic t_esc;
    u_mmlc_host.send(8'h55);
    idle(G + 10);
    line("++x");
    idle(G + 10);
    chk("air", 32'h552B2B78, {air[0], air[1], air[2], air[3]});
    line("+++");
    idle(3 * G);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("mode", 1'b1, rdv[0]);
    reply_chk();
    chk("air count", 32'h4, air.size());
    chk("leds", 6'h00, leds);
    line("AT&W\r");
    idle(4);
    chk("stores", 32'h1, stores);
  endtask
  task automatic t_cmd;
    line("ATS123=?\r");
    idle(4);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("class", 32'h4, rdv[6:4]);
    bus(1'b0, OFF_REGNUM, 32'h0);
    chk("regnum", 32'h7B, rdv);
    line("ATS5/?\r");
    idle(4);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("class", 32'h5, rdv[6:4]);
    line("AT&V\r");
    idle(4);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("class", 32'h3, rdv[6:4]);
    {rf_rx_valid, rf_rx_data} <= 9'h1A5;
    do @(posedge core_clk); while (!rf_rx_ready);
    rf_rx_valid <= 1'b0;
    bus(1'b1, OFF_TXDATA, 32'h41);
    idle(6);
    chk("host bytes", 32'h1, u_mmlc_host.got.size());
    chk("sw byte", 32'h41, u_mmlc_host.got.pop_front());
  endtask
  task automatic t_acq;
    logic [2:0] b;
    line("ATA\r");
    bus(1'b1, OFF_CTRL, 32'h03);
    rf_synced <= 1'b0;
    idle(4);
    b = leds.signal_strength_bar;
    chk("acq leds", 32'h0, leds[5:3]);
    chk("acq one-hot", 32'h1, $onehot(b));
    b = (b == 3'h4) ? 3'h1 : 3'(b << 1);
    idle(10);
    chk("acq step", b, leds.signal_strength_bar);
    clk_en <= 1'b0;
    idle(2);
    b = leds.signal_strength_bar;
    idle(20);
    chk("frozen bar", b, leds.signal_strength_bar);
    clk_en <= 1'b1;
    rf_synced <= 1'b1;
    {rf_pkt_ok, rf_pkt_level} <= 9'h190;
    idle(1);
    rf_pkt_ok <= 1'b0;
    idle(3);
    chk("synced leds", 32'h1B, leds);
    {rf_rx_valid, rf_rx_data} <= 9'h15A;
    do @(posedge core_clk); while (!rf_rx_ready);
    rf_rx_valid <= 1'b0;
    idle(4);
    chk("air to host", 32'h5A, u_mmlc_host.got.pop_front());
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    idle(20);
    arst_n <= 1'b1;
    idle(10);
    cfg_button_n <= 1'b1;
    t_boot();
    t_leds();
    t_esc();
    t_cmd();
    t_acq();
    tally_and_finish();
  end
endmodule
`default_nettype wire
